// ===== common/tpu_pkg.sv
// constants, types and flag helpers for the timer flag and buffer logic
package tpu_pkg;
  localparam int          NCH        = 2;
  // register byte offsets
  localparam logic [7:0]  SC_OFS     = 8'h00;
  localparam logic [7:0]  CNTH_OFS   = 8'h04;
  localparam logic [7:0]  CNTL_OFS   = 8'h08;
  localparam logic [7:0]  MODH_OFS   = 8'h0C;
  localparam logic [7:0]  MODL_OFS   = 8'h10;
  localparam logic [7:0]  CH_BASE    = 8'h20;
  localparam logic [7:0]  CH_STRIDE  = 8'h10;
  localparam logic [7:0]  CSC_OFS    = 8'h00;
  localparam logic [7:0]  CVH_OFS    = 8'h04;
  localparam logic [7:0]  CVL_OFS    = 8'h08;
  // timer status/control fields
  localparam int          SC_FLAG    = 7;
  localparam int          SC_IE      = 6;
  localparam int          SC_CPWM    = 5;
  localparam int          SC_CLK_HI  = 4;
  localparam int          SC_CLK_LO  = 3;
  localparam int          SC_PS_HI   = 2;
  localparam int          SC_PS_LO   = 0;
  localparam logic [6:0]  SC_RST     = 7'h00;
  // channel status/control fields
  localparam int          CSC_FLAG   = 7;
  localparam int          CSC_IE     = 6;
  localparam int          CSC_MS_HI  = 5;
  localparam int          CSC_MS_LO  = 4;
  localparam int          CSC_EL_HI  = 3;
  localparam int          CSC_EL_LO  = 2;
  localparam logic [5:2]  CSC_RST    = 4'h0;
  // counter values
  localparam logic [15:0] CNT_ZERO   = 16'h0000;
  localparam logic [15:0] CNT_ONE    = 16'h0001;
  localparam logic [15:0] CNT_MAX    = 16'hFFFF;
  localparam logic [15:0] CNT_PRE    = 16'hFFFE;
  localparam logic [6:0]  PRE_ZERO   = 7'h00;

  typedef enum logic [1:0] {
    TPU_EDGE_OFF  = 2'b00,
    TPU_EDGE_RISE = 2'b01,
    TPU_EDGE_FALL = 2'b10,
    TPU_EDGE_BOTH = 2'b11
  } tpu_edge_t;

  typedef enum logic {
    TPU_UP   = 1'b0,
    TPU_DOWN = 1'b1
  } tpu_dir_t;

  // set wins over clear
  function automatic logic tpu_flag_nxt(input logic flag, input logic set, input logic clr);
    return set | (flag & ~clr);
  endfunction

  // arm on read-while-one, a write to the flag's own status register or a new event ends the sequence
  function automatic logic tpu_arm_nxt(input logic arm, input logic set, input logic rd_one,
                                       input logic wr);
    return ~set & (rd_one | (arm & ~wr));
  endfunction
endpackage

// ===== src/tpu_chan.sv
// one timer channel: event flag, value buffering and read coherency
`timescale 1ns/1ps
module tpu_chan (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // counter side
  input  wire logic [15:0] cnt,
  input  wire logic        tick,
  input  wire logic        load_pt,
  input  wire logic        clk_off,
  input  wire logic        cpwm,
  input  wire logic        halt,
  input  wire logic        cap_in,
  // register strobes
  input  wire logic        wr_csc,
  input  wire logic        wr_vh,
  input  wire logic        wr_vl,
  input  wire logic        rd_csc,
  input  wire logic        rd_vh,
  input  wire logic        rd_vl,
  input  wire logic [7:0]  wdata,
  // read data and request
  output logic      [7:0]  csc_q,
  output logic      [7:0]  vh_q,
  output logic      [7:0]  vl_q,
  output logic             irq_req
);
  logic        flag_ff;
  logic        arm_ff;
  logic [5:2]  ctl_ff;
  logic        ie_ff;
  logic        cap_d_ff;
  logic [15:0] val_ff;
  logic [15:0] buf_ff;
  logic        hi_w_ff;
  logic        lo_w_ff;
  logic        rl_v_ff;
  logic        rl_hi_ff;
  logic [7:0]  rl_ff;
  logic        capture;
  logic        compare;
  logic        cap_evt;
  logic        evt;
  logic        load;
  tpu_pkg::tpu_edge_t edge_sel;

  assign capture  = ~cpwm & (ctl_ff[5:4] == 2'b00);
  assign compare  = ~cpwm & (ctl_ff[5:4] == 2'b01);
  assign edge_sel = tpu_pkg::tpu_edge_t'(ctl_ff[3:2]);

  always_comb begin
    unique case (edge_sel)
      tpu_pkg::TPU_EDGE_OFF:  cap_evt = 1'b0;
      tpu_pkg::TPU_EDGE_RISE: cap_evt = cap_in & ~cap_d_ff;
      tpu_pkg::TPU_EDGE_FALL: cap_evt = ~cap_in & cap_d_ff;
      tpu_pkg::TPU_EDGE_BOTH: cap_evt = cap_in ^ cap_d_ff;
    endcase
  end

  // capture edge, compare or pwm match
  assign evt  = (capture & cap_evt) |
                (~capture & tick & (cnt == val_ff));
  assign load = hi_w_ff & lo_w_ff &
                (clk_off | (compare & tick) | (~compare & load_pt));

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cap_d_ff <= 1'b0;
    end else begin
      cap_d_ff <= cap_in;
    end
  end

  // event flag with two-step clear
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      flag_ff <= 1'b0;
      arm_ff  <= 1'b0;
    end else begin
      flag_ff <= tpu_pkg::tpu_flag_nxt(flag_ff, evt,
        wr_csc & ~wdata[tpu_pkg::CSC_FLAG] & arm_ff);
      arm_ff  <= tpu_pkg::tpu_arm_nxt(arm_ff, evt, rd_csc & flag_ff, wr_csc);
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctl_ff <= tpu_pkg::CSC_RST;
      ie_ff  <= 1'b0;
    end else if (wr_csc) begin
      ctl_ff <= wdata[tpu_pkg::CSC_MS_HI:tpu_pkg::CSC_EL_LO];
      ie_ff  <= wdata[tpu_pkg::CSC_IE];
    end
  end

  // value write buffer
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      buf_ff  <= tpu_pkg::CNT_ZERO;
      hi_w_ff <= 1'b0;
      lo_w_ff <= 1'b0;
    end else if (wr_csc || capture) begin
      hi_w_ff <= 1'b0;
      lo_w_ff <= 1'b0;
    end else if (load) begin
      hi_w_ff <= 1'b0;
      lo_w_ff <= 1'b0;
    end else begin
      if (wr_vh) begin
        buf_ff[15:8] <= wdata;
        hi_w_ff      <= 1'b1;
      end
      if (wr_vl) begin
        buf_ff[7:0] <= wdata;
        lo_w_ff     <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      val_ff <= tpu_pkg::CNT_ZERO;
    end else if (capture && cap_evt) begin
      val_ff <= cnt;
    end else if (!capture && load) begin
      val_ff <= buf_ff;
    end
  end

  // read coherency latch
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rl_v_ff  <= 1'b0;
      rl_hi_ff <= 1'b0;
      rl_ff    <= 8'h00;
    end else if (wr_csc) begin
      rl_v_ff <= 1'b0;
    end else if (!halt) begin
      if (rd_vh) begin
        rl_v_ff  <= ~(rl_v_ff & rl_hi_ff);
        rl_hi_ff <= 1'b0;
        rl_ff    <= val_ff[7:0];
      end else if (rd_vl) begin
        rl_v_ff  <= ~(rl_v_ff & ~rl_hi_ff);
        rl_hi_ff <= 1'b1;
        rl_ff    <= val_ff[15:8];
      end
    end
  end

  assign vh_q    = (!halt && rl_v_ff && rl_hi_ff) ? rl_ff : val_ff[15:8];
  assign vl_q    = (!halt && rl_v_ff && !rl_hi_ff) ? rl_ff : val_ff[7:0];
  assign csc_q   = {flag_ff, ie_ff, ctl_ff, 2'b00};
  assign irq_req = flag_ff & ie_ff;
endmodule // tpu_chan

// ===== src/tpu_top.sv
// timer counter, overflow flag, bus slave and channel instances
//
// The address map and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module tpu_top (
  // clock and reset
  input  wire logic                     mclk,
  input  wire logic                     reset_n,
  // avalon-mm slave
  input  wire logic [7:0]               avs_address,
  input  wire logic                     avs_read,
  input  wire logic                     avs_write,
  input  wire logic [31:0]              avs_writedata,
  input  wire logic [3:0]               avs_byteenable,
  output logic      [31:0]              avs_readdata,
  output logic                          avs_waitrequest,
  // debug and capture pins
  input  wire logic                     debug_halt,
  input  wire logic [tpu_pkg::NCH-1:0]  chan_pin,
  // interrupt request
  output logic                          irq
);
  logic                    ack_ff;
  logic [31:0]             rdata_ff;
  logic                    rd;
  logic                    wr;
  logic [7:0]              wd;
  logic                    wr_sc;
  logic                    wr_cnt;
  logic                    wr_mh;
  logic                    wr_ml;
  logic                    rd_sc;
  logic                    rd_ch;
  logic                    rd_cl;
  logic [tpu_pkg::NCH-1:0] pin_s1_ff;
  logic [tpu_pkg::NCH-1:0] pin_s2_ff;
  logic [6:0]              ctl_ff;
  logic                    tof_ff;
  logic                    tof_arm_ff;
  logic                    tof_evt;
  logic [6:0]              pre_ff;
  logic [15:0]             cnt_ff;
  logic [15:0]             nxt_cnt;
  tpu_pkg::tpu_dir_t       dir_ff;
  tpu_pkg::tpu_dir_t       nxt_dir;
  logic [15:0]             mod_ff;
  logic [15:0]             mbuf_ff;
  logic                    mh_w_ff;
  logic                    ml_w_ff;
  logic                    rl_v_ff;
  logic                    rl_hi_ff;
  logic [7:0]              rl_ff;
  logic                    clk_off;
  logic                    cpwm;
  logic                    tick;
  logic                    load_pt;
  logic [15:0]             term;
  logic [6:0]              pmask;
  logic [7:0]              cnth_q;
  logic [7:0]              cntl_q;
  logic [7:0]              rbyte;
  logic [tpu_pkg::NCH-1:0] ch_irq;
  logic [7:0]              ch_csc  [tpu_pkg::NCH];
  logic [7:0]              ch_vh   [tpu_pkg::NCH];
  logic [7:0]              ch_vl   [tpu_pkg::NCH];
  logic [tpu_pkg::NCH-1:0] wr_csc;
  logic [tpu_pkg::NCH-1:0] wr_vh;
  logic [tpu_pkg::NCH-1:0] wr_vl;
  logic [tpu_pkg::NCH-1:0] rd_csc;
  logic [tpu_pkg::NCH-1:0] rd_vh;
  logic [tpu_pkg::NCH-1:0] rd_vl;

  function automatic logic [7:0] ch_adr(input int idx, input logic [7:0] ofs);
    logic [7:0] base;
    base = tpu_pkg::CH_BASE + 8'(idx) * tpu_pkg::CH_STRIDE;
    return base + ofs;
  endfunction

  function automatic logic [6:0] ps_mask(input logic [2:0] ps);
    return 7'((8'h01 << ps) - 8'h01);
  endfunction

  // bus handshake: one wait state, action at the first edge
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
  assign avs_readdata    = rdata_ff;
  assign rd              = avs_read & ~ack_ff;
  assign wr              = avs_write & ~avs_read & ~ack_ff & avs_byteenable[0];
  assign wd              = avs_writedata[7:0];
  assign wr_sc           = wr & (avs_address == tpu_pkg::SC_OFS);
  assign wr_cnt          = wr & ((avs_address == tpu_pkg::CNTH_OFS) |
                                 (avs_address == tpu_pkg::CNTL_OFS));
  assign wr_mh           = wr & (avs_address == tpu_pkg::MODH_OFS);
  assign wr_ml           = wr & (avs_address == tpu_pkg::MODL_OFS);
  assign rd_sc           = rd & (avs_address == tpu_pkg::SC_OFS);
  assign rd_ch           = rd & (avs_address == tpu_pkg::CNTH_OFS);
  assign rd_cl           = rd & (avs_address == tpu_pkg::CNTL_OFS);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (avs_read | avs_write) & ~ack_ff;
    end
  end

  // capture pin synchronisers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
    end else begin
      pin_s1_ff <= chan_pin;
      pin_s2_ff <= pin_s1_ff;
    end
  end

  // timer status/control
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctl_ff <= tpu_pkg::SC_RST;
    end else if (wr_sc) begin
      ctl_ff <= wd[tpu_pkg::SC_IE:tpu_pkg::SC_PS_LO];
    end
  end

  assign clk_off = (ctl_ff[tpu_pkg::SC_CLK_HI:tpu_pkg::SC_CLK_LO] == 2'b00);
  assign cpwm    = ctl_ff[tpu_pkg::SC_CPWM];
  assign pmask   = ps_mask(ctl_ff[tpu_pkg::SC_PS_HI:tpu_pkg::SC_PS_LO]);
  assign tick    = ~clk_off & ~debug_halt & ((pre_ff & pmask) == pmask);
  assign term    = (mod_ff == tpu_pkg::CNT_ZERO) ? tpu_pkg::CNT_MAX : mod_ff;
  assign load_pt = tick & (~cpwm | (dir_ff == tpu_pkg::TPU_UP)) &
                   (cnt_ff == ((mod_ff == tpu_pkg::CNT_ZERO) ?
                               tpu_pkg::CNT_PRE : mod_ff - tpu_pkg::CNT_ONE));

  // prescaler
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pre_ff <= tpu_pkg::PRE_ZERO;
    end else if (wr_cnt || tick) begin
      pre_ff <= tpu_pkg::PRE_ZERO;
    end else if (!clk_off && !debug_halt) begin
      pre_ff <= pre_ff + 7'h01;
    end
  end

  // counter next value and overflow event
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_dir = dir_ff;
    tof_evt = 1'b0;
    if (wr_cnt) begin
      nxt_cnt = tpu_pkg::CNT_ZERO;
      nxt_dir = tpu_pkg::TPU_UP;
    end else if (tick && cpwm) begin
      unique case (dir_ff)
        tpu_pkg::TPU_UP: begin
          if (cnt_ff == mod_ff) begin
            nxt_cnt = cnt_ff - tpu_pkg::CNT_ONE;
            nxt_dir = tpu_pkg::TPU_DOWN;
            tof_evt = 1'b1;
          end else begin
            nxt_cnt = cnt_ff + tpu_pkg::CNT_ONE;
          end
        end
        tpu_pkg::TPU_DOWN: begin
          if (cnt_ff == tpu_pkg::CNT_ZERO) begin
            nxt_cnt = tpu_pkg::CNT_ONE;
            nxt_dir = tpu_pkg::TPU_UP;
          end else begin
            nxt_cnt = cnt_ff - tpu_pkg::CNT_ONE;
          end
        end
      endcase
    end else if (tick) begin
      nxt_dir = tpu_pkg::TPU_UP;
      if (cnt_ff == term) begin
        nxt_cnt = tpu_pkg::CNT_ZERO;
        tof_evt = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + tpu_pkg::CNT_ONE;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= tpu_pkg::CNT_ZERO;
      dir_ff <= tpu_pkg::TPU_UP;
    end else begin
      cnt_ff <= nxt_cnt;
      dir_ff <= nxt_dir;
    end
  end

  // overflow flag with two-step clear
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tof_ff     <= 1'b0;
      tof_arm_ff <= 1'b0;
    end else begin
      tof_ff     <= tpu_pkg::tpu_flag_nxt(tof_ff, tof_evt,
        wr_sc & ~wd[tpu_pkg::SC_FLAG] & tof_arm_ff);
      tof_arm_ff <= tpu_pkg::tpu_arm_nxt(tof_arm_ff, tof_evt, rd_sc & tof_ff, wr_sc);
    end
  end

  // modulo write buffer
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mod_ff  <= tpu_pkg::CNT_ZERO;
      mbuf_ff <= tpu_pkg::CNT_ZERO;
      mh_w_ff <= 1'b0;
      ml_w_ff <= 1'b0;
    end else if (wr_sc) begin
      mh_w_ff <= 1'b0;
      ml_w_ff <= 1'b0;
    end else if (mh_w_ff && ml_w_ff && (clk_off || tick)) begin
      mod_ff  <= mbuf_ff;
      mh_w_ff <= 1'b0;
      ml_w_ff <= 1'b0;
    end else begin
      if (wr_mh) begin
        mbuf_ff[15:8] <= wd;
        mh_w_ff       <= 1'b1;
      end
      if (wr_ml) begin
        mbuf_ff[7:0] <= wd;
        ml_w_ff      <= 1'b1;
      end
    end
  end

  // counter read coherency latch
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rl_v_ff  <= 1'b0;
      rl_hi_ff <= 1'b0;
      rl_ff    <= 8'h00;
    end else if (wr_sc || wr_cnt) begin
      rl_v_ff <= 1'b0;
    end else if (!debug_halt) begin
      if (rd_ch) begin
        rl_v_ff  <= ~(rl_v_ff & rl_hi_ff);
        rl_hi_ff <= 1'b0;
        rl_ff    <= cnt_ff[7:0];
      end else if (rd_cl) begin
        rl_v_ff  <= ~(rl_v_ff & ~rl_hi_ff);
        rl_hi_ff <= 1'b1;
        rl_ff    <= cnt_ff[15:8];
      end
    end
  end

  assign cnth_q = (!debug_halt && rl_v_ff && rl_hi_ff) ? rl_ff : cnt_ff[15:8];
  assign cntl_q = (!debug_halt && rl_v_ff && !rl_hi_ff) ? rl_ff : cnt_ff[7:0];

  // channels
  for (genvar i = 0; i < tpu_pkg::NCH; i++) begin : g_ch
    assign wr_csc[i] = wr & (avs_address == ch_adr(i, tpu_pkg::CSC_OFS));
    assign wr_vh[i]  = wr & (avs_address == ch_adr(i, tpu_pkg::CVH_OFS));
    assign wr_vl[i]  = wr & (avs_address == ch_adr(i, tpu_pkg::CVL_OFS));
    assign rd_csc[i] = rd & (avs_address == ch_adr(i, tpu_pkg::CSC_OFS));
    assign rd_vh[i]  = rd & (avs_address == ch_adr(i, tpu_pkg::CVH_OFS));
    assign rd_vl[i]  = rd & (avs_address == ch_adr(i, tpu_pkg::CVL_OFS));

    tpu_chan u_chan (
      .mclk    (mclk),
      .reset_n (reset_n),
      .cnt     (cnt_ff),
      .tick    (tick),
      .load_pt (load_pt),
      .clk_off (clk_off),
      .cpwm    (cpwm),
      .halt    (debug_halt),
      .cap_in  (pin_s2_ff[i]),
      .wr_csc  (wr_csc[i]),
      .wr_vh   (wr_vh[i]),
      .wr_vl   (wr_vl[i]),
      .rd_csc  (rd_csc[i]),
      .rd_vh   (rd_vh[i]),
      .rd_vl   (rd_vl[i]),
      .wdata   (wd),
      .csc_q   (ch_csc[i]),
      .vh_q    (ch_vh[i]),
      .vl_q    (ch_vl[i]),
      .irq_req (ch_irq[i])
    );
  end

  // read mux, unmapped reads as zero
  always_comb begin
    rbyte = 8'h00;
    unique case (avs_address)
      tpu_pkg::SC_OFS:   rbyte = {tof_ff, ctl_ff};
      tpu_pkg::CNTH_OFS: rbyte = cnth_q;
      tpu_pkg::CNTL_OFS: rbyte = cntl_q;
      tpu_pkg::MODH_OFS: rbyte = mod_ff[15:8];
      tpu_pkg::MODL_OFS: rbyte = mod_ff[7:0];
      default:           rbyte = 8'h00;
    endcase
    for (int k = 0; k < tpu_pkg::NCH; k++) begin
      if (avs_address == ch_adr(k, tpu_pkg::CSC_OFS)) begin
        rbyte = ch_csc[k];
      end
      if (avs_address == ch_adr(k, tpu_pkg::CVH_OFS)) begin
        rbyte = ch_vh[k];
      end
      if (avs_address == ch_adr(k, tpu_pkg::CVL_OFS)) begin
        rbyte = ch_vl[k];
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_ff <= 32'h0000_0000;
    end else if (rd) begin
      rdata_ff <= {24'h00_0000, rbyte};
    end
  end

  assign irq = (tof_ff & ctl_ff[tpu_pkg::SC_IE]) | (|ch_irq);
endmodule // tpu_top

// ===== dv/tpu_top_chk.sv
// assertion checker for the timer flag and buffer logic
`timescale 1ns/1ps
module tpu_top_chk (
  // clock and reset
  input wire logic                    mclk,
  input wire logic                    reset_n,
  // avalon-mm slave
  input wire logic [7:0]              avs_address,
  input wire logic                    avs_read,
  input wire logic                    avs_write,
  input wire logic [31:0]             avs_writedata,
  input wire logic [3:0]              avs_byteenable,
  input wire logic [31:0]             avs_readdata,
  input wire logic                    avs_waitrequest,
  // pins and request
  input wire logic                    debug_halt,
  input wire logic [tpu_pkg::NCH-1:0] chan_pin,
  input wire logic                    irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic req;
  logic unmapped;
  logic ctl_reg;
  assign req = avs_read | avs_write;
  assign unmapped = (avs_address[1:0] != 2'h0) || (avs_address > 8'h10 && avs_address < 8'h20)
    || (avs_address >= 8'h40) || (avs_address >= 8'h20 && avs_address[3:0] == 4'hC);
  assign ctl_reg = (avs_address == 8'h00) || (avs_address >= 8'h20 && avs_address < 8'h40
                    && avs_address[3:0] == 4'h0);
  sequence s_taken;
    req && avs_waitrequest;
  endsequence
  sequence s_answer;
    req && !avs_waitrequest;
  endsequence
  AST_TAKE_WAIT: assert property ($rose(req) |-> avs_waitrequest)
    else $error("request not held off in its first cycle");
  AST_ONE_WAIT: assert property (s_taken |=> s_answer)
    else $error("wait state not exactly one cycle");
  AST_IDLE_NOWAIT: assert property (!req |-> !avs_waitrequest)
    else $error("waitrequest high with no request");
  AST_RDATA_UPPER: assert property (avs_readdata[31:8] == 24'h00_0000)
    else $error("upper read data not zero");
  AST_UNMAPPED_ZERO: assert property (s_answer ##0 avs_read && unmapped |->
    avs_readdata == 32'h0000_0000)
    else $error("unmapped read returned data");
  AST_RST_QUIET: assert property ($rose(reset_n) |->
    !irq && avs_readdata == 32'h0000_0000)
    else $error("state not clear after reset");
  AST_IRQ_LEVEL: assert property (s_answer ##0 avs_read && ctl_reg &&
    avs_readdata[7:6] == 2'b11 |-> irq)
    else $error("enabled flag read as set without request");
  AST_IRQ_HOLD: assert property (irq && !(avs_write && avs_waitrequest) |=> irq)
    else $error("request dropped without a write");
  AST_NO_CLR_ON_ONE: assert property (irq ##0 s_taken ##0 avs_write &&
    avs_writedata[7:6] == 2'b11 |=> irq)
    else $error("writing one dropped the request");
  AST_RD_STANDS: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
    else $error("read data changed without a read");
endmodule // tpu_top_chk

bind tpu_top tpu_top_chk u_chk (.mclk(mclk), .reset_n(reset_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .debug_halt(debug_halt), .chan_pin(chan_pin), .irq(irq));

// ===== dv/tpu_host_model.sv
// avalon-mm host software model for the timer registers
`timescale 1ns/1ps
module tpu_host_model (
  // clock
  input  wire logic        mclk,
  // avalon-mm master
  output logic      [7:0]  avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic      [31:0] avs_writedata,
  output logic      [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest
);
  initial begin
    avs_address    = 8'h00;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0000_0000;
    avs_byteenable = 4'hF;
  end
  // one held request, released only after waitrequest seen low
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge mclk);
    avs_address   <= a;
    avs_read      <= ~w;
    avs_write     <= w;
    avs_writedata <= {24'h00_0000, d};
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(a, 1'b1, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    xfer(a, 1'b0, 8'h00, q);
  endtask
  task automatic clr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    rd(a, q);
    wr(a, d & 8'h7F);
  endtask
  task automatic poll(input logic [7:0] a, input logic [15:0] e, output logic ok);
    logic [7:0] h;
    logic [7:0] l;
    ok = 1'b0;
    for (int i = 0; i < 8 && !ok; i++) begin
      rd(a + 8'h04, h);
      rd(a + 8'h08, l);
      ok = ({h, l} === e);
    end
  endtask
endmodule // tpu_host_model

// ===== dv/tb.sv
// self-checking testbench for the timer flag and buffer logic
`timescale 1ns/1ps
module tb;
  logic                    mclk;
  logic                    reset_n;
  logic [7:0]              avs_address;
  logic                    avs_read;
  logic                    avs_write;
  logic [31:0]             avs_writedata;
  logic [3:0]              avs_byteenable;
  logic [31:0]             avs_readdata;
  logic                    avs_waitrequest;
  logic                    debug_halt;
  logic [tpu_pkg::NCH-1:0] chan_pin;
  logic                    irq;
  logic [7:0]              q;
  logic [15:0]             v;
  logic                    ok;
  int                      fails;
  int                      check_count;
  int                      cycles;

  tpu_top u_tpu_top (.mclk(mclk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .debug_halt(debug_halt), .chan_pin(chan_pin), .irq(irq));
  tpu_host_model u_host (.mclk(mclk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 90000) begin
      fails++;
      conclude();
    end
  end

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic rdv(input logic [7:0] a, output logic [15:0] r);
    logic [7:0] h;
    logic [7:0] l;
    u_host.rd(a + 8'h04, h);
    u_host.rd(a + 8'h08, l);
    r = {h, l};
  endtask

  task automatic t_reset();
    u_host.rd(8'h00, q);
    chk("status", 16'h0000, 16'(q));
    chk("irq", 16'h0000, 16'(irq));
    u_host.rd(8'h2C, q);
    chk("unmapped", 16'h0000, 16'(q));
  endtask
  task automatic t_ovf();
    u_host.wr(8'h0C, 8'h00);
    u_host.wr(8'h10, 8'h07);
    u_host.wr(8'h00, 8'h08);
    repeat (12) @(posedge mclk);
    u_host.rd(8'h00, q);
    chk("ovf set", 16'h0001, 16'(q[7]));
    repeat (12) @(posedge mclk);
    u_host.wr(8'h00, 8'h00);
    u_host.rd(8'h00, q);
    chk("ovf kept", 16'h0001, 16'(q[7]));
    u_host.wr(8'h00, 8'hC0);
    chk("irq on", 16'h0001, 16'(irq));
    u_host.wr(8'h00, 8'hC0);
    u_host.wr(8'h00, 8'h40);
    u_host.rd(8'h00, q);
    chk("ovf held", 16'h00C0, 16'(q));
    u_host.wr(8'h00, 8'h40);
    chk("irq off", 16'h0000, 16'(irq));
    u_host.rd(8'h00, q);
    chk("ovf clear", 16'h0040, 16'(q));
  endtask
  task automatic t_free();
    u_host.wr(8'h0C, 8'h00);
    u_host.wr(8'h10, 8'h00);
    u_host.wr(8'h00, 8'h08);
    u_host.wr(8'h08, 8'h00);
    repeat (65500) @(posedge mclk);
    u_host.rd(8'h00, q);
    chk("wrap early", 16'h0000, 16'(q[7]));
    repeat (60) @(posedge mclk);
    u_host.rd(8'h00, q);
    chk("wrap", 16'h0001, 16'(q[7]));
  endtask
  task automatic t_cnt();
    debug_halt <= 1'b1;
    u_host.wr(8'h04, 8'h00);
    rdv(8'h00, v);
    chk("count cleared", 16'h0000, v);
    debug_halt <= 1'b0;
    u_host.rd(8'h04, q);
    repeat (20) @(posedge mclk);
    debug_halt <= 1'b1;
    u_host.rd(8'h08, q);
    chk("live low", 16'h0001, 16'(q >= 8'h10));
    u_host.wr(8'h00, 8'h00);
    debug_halt <= 1'b0;
    u_host.rd(8'h08, q);
    chk("latch reset", 16'h0001, 16'(q >= 8'h10));
  endtask
  task automatic t_chan();
    logic [7:0] md [3];
    logic [7:0] sc [3];
    md = '{8'h50, 8'h60, 8'h60};
    sc = '{8'h08, 8'h08, 8'h28};
    u_host.wr(8'h24, 8'h12);
    u_host.wr(8'h28, 8'h34);
    rdv(8'h20, v);
    chk("capture value", 16'h0000, v);
    u_host.wr(8'h20, 8'h10);
    u_host.wr(8'h24, 8'h00);
    u_host.wr(8'h28, 8'h05);
    rdv(8'h20, v);
    chk("value no clock", 16'h0005, v);
    u_host.wr(8'h28, 8'h09);
    u_host.wr(8'h20, 8'h10);
    u_host.wr(8'h24, 8'h00);
    rdv(8'h20, v);
    chk("value discarded", 16'h0005, v);
    for (int i = 0; i < 3; i++) begin
      u_host.wr(8'h00, 8'h00);
      u_host.clr(8'h00, 8'h00);
      u_host.clr(8'h20, md[i]);
      u_host.wr(8'h0C, 8'h00);
      u_host.wr(8'h10, 8'h07);
      u_host.wr(8'h08, 8'h00);
      u_host.wr(8'h00, sc[i]);
      repeat (16) @(posedge mclk);
      u_host.rd(8'h00, q);
      chk("ovf", 16'h0001, 16'(q[7]));
      u_host.rd(8'h20, q);
      chk("match", 16'h0001, 16'(q[7]));
      chk("chan irq", 16'h0001, 16'(irq));
    end
    u_host.wr(8'h00, 8'h00);
    u_host.clr(8'h20, 8'h10);
    chk("chan irq off", 16'h0000, 16'(irq));
    u_host.wr(8'h00, 8'h08);
    u_host.wr(8'h24, 8'h00);
    u_host.wr(8'h28, 8'h06);
    u_host.poll(8'h20, 16'h0006, ok);
    chk("buffer load", 16'h0001, 16'(ok));
    debug_halt <= 1'b1;
    u_host.wr(8'h20, 8'h20);
    u_host.wr(8'h24, 8'h00);
    u_host.wr(8'h28, 8'h03);
    rdv(8'h20, v);
    chk("pwm held", 16'h0006, v);
    debug_halt <= 1'b0;
    u_host.poll(8'h20, 16'h0003, ok);
    chk("pwm load", 16'h0001, 16'(ok));
    u_host.wr(8'h00, 8'h00);
  endtask
  task automatic t_cap();
    for (int s = 0; s < 4; s++) begin
      u_host.clr(8'h30, 8'(s << 2));
      chan_pin[1] <= 1'b1;
      repeat (6) @(posedge mclk);
      u_host.rd(8'h30, q);
      chk("rise", 16'(s[0]), 16'(q[7]));
      u_host.clr(8'h30, 8'(s << 2));
      chan_pin[1] <= 1'b0;
      repeat (6) @(posedge mclk);
      u_host.rd(8'h30, q);
      chk("fall", 16'(s[1]), 16'(q[7]));
    end
  endtask

  initial begin
    reset_n    = 1'b0;
    debug_halt = 1'b0;
    chan_pin   = '0;
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    t_reset();
    t_ovf();
    t_free();
    t_cnt();
    t_chan();
    t_cap();
    conclude();
  end
endmodule // tb
